/* File: design/ppp_pkg.sv */
// Package for the bidirectional parallel host port.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package ppp_pkg;

    // ==================================================
    // Register map (byte addresses, one word each)
    localparam logic [3:0] ADDR_DATA_LATCH = 4'h0;
    localparam logic [3:0] ADDR_PORT_STATUS = 4'h4;
    localparam logic [3:0] ADDR_LINE_READBACK = 4'h8;
    localparam logic [3:0] ADDR_LINE_DRIVE = 4'hc;
    localparam logic [3:0] ADDR_DIR_CODE = 4'h0;
    localparam logic [1:0] ADDR_SEL_BITS = 2'h0;

    // ==================================================
    // Direction codes
    localparam logic [7:0] DIR_CODE_OUT = 8'h55;
    localparam logic [7:0] DIR_CODE_IN = 8'haa;

    // ==================================================
    // Line drive setting fields
    localparam int CTL_STROBE = 0;
    localparam int CTL_LFEED = 1;
    localparam int CTL_RESTART = 2;
    localparam int CTL_SELREQ = 3;
    localparam int CTL_IRQ_EN = 4;
    localparam int CTL_DIR = 5;

    // ==================================================
    // Port status fields
    localparam int STS_IRQ = 2;
    localparam int STS_ERROR = 3;
    localparam int STS_SELECTED = 4;
    localparam int STS_PAPER = 5;
    localparam int STS_ACK = 6;
    localparam int STS_BUSY = 7;

    // ==================================================
    // Reset values and constant bits
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [5:0] CTL_RESET = 6'h00;
    localparam logic [7:0] STS_UNUSED = 8'h03;
    localparam logic [7:0] RBK_UNUSED = 8'he0;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // Status inputs from the printer side
    typedef struct packed {
        logic busy;
        logic ack_n;
        logic paper_empty_in;
        logic selected_in;
        logic error_n;
    } printer_status_s;

    // Open-drain handshake line group: one bit per line
    typedef struct packed {
        logic strobe_n;
        logic line_feed_ctrl;
        logic restart;
        logic select_request_out;
    } hs_lines_s;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_e;

endpackage

/* File: design/ppp_sync2.sv */
// Two-flop synchroniser for a bundle of level inputs.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module ppp_sync2 #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] d_i,
    input wire logic [WIDTH-1:0] rst_val_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '1;
            q_o <= '1;
        end else if (ce_i) begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end

    // rst_val_i reserved for callers wanting a documented idle; unused here
    logic unused_rst_val;
    assign unused_rst_val = ^rst_val_i;
endmodule
`default_nettype wire

/* File: design/ppp_ack_latch.sv */
// Interrupt-pending flag for the acknowledge input, tracking or latched.
// Assumes ack_n_i is already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none
module ppp_ack_latch (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic ack_n_i,
    input wire logic latch_sel_i,
    input wire logic status_read_i,
    output logic pending_n_o
);
    logic latched_n_reg;

    // ==================================================
    // Latched copy: a low ack beats a status read in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched_n_reg <= 1'b1;
        end else if (ce_i) begin
            if (!ack_n_i) begin
                latched_n_reg <= 1'b0;
            end else if (status_read_i) begin
                latched_n_reg <= 1'b1;
            end
        end
    end

    always_comb begin
        if (latch_sel_i) begin
            pending_n_o = latched_n_reg;
        end else begin
            pending_n_o = ack_n_i;
        end
    end
endmodule
`default_nettype wire

/* File: design/printer_parallel_port.sv */
// Bidirectional printer parallel port with a classic Wishbone register slave.
// Assumes pin inputs are asynchronous; open-drain wires resolved outside.
//
// Operation
// - The data latch holds a byte, bit 0 least significant, driven in output mode.
// - With pin mode low, writing 0x55 selects output and 0xaa selects input.
// - The direction code is ignored while the pin mode input is high.
// - With pin mode high, drive bit 5 selects direction, 0 out and 1 in.
// - Unused status bits 1-0, readback bits 7-5 and drive bits 7-6 read as 1.
// - With latch select low, status bit 2 follows the acknowledge input.
// - With latch select high, status bit 2 latches low until a status read.
// - Status bits 3 to 7 give error, selected, paper, acknowledge and busy.
// - Readback bits 0, 1, 3 are inverted pin levels, bit 2 the true level.
// - Readback bit 4 returns the interrupt enable setting.
// - The strobe is low while drive bit 0 is 1; software ends the pulse.
// - Drive bits 1 to 3 set line feed low, restart high, select request low.
// - Handshake lines are open drain and read back from the actual pins.
// - Drive bit 4 masks or enables the printer interrupt output.
// - All drive bits except direction are readable through the readback.
`timescale 1ns/1ps
`default_nettype none
module printer_parallel_port
    import ppp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Mode straps
    input wire logic direction_pin_mode_i,
    input wire logic ack_latch_select_i,
    // Data pins
    input wire logic [7:0] parallel_data_pins_i,
    output logic [7:0] parallel_data_pins_o,
    output logic [7:0] parallel_data_pins_oe_o,
    // Handshake lines, open drain
    input wire ppp_pkg::hs_lines_s hs_pins_i,
    output ppp_pkg::hs_lines_s hs_pins_o,
    output ppp_pkg::hs_lines_s hs_pins_oe_o,
    // Printer status
    input wire ppp_pkg::printer_status_s printer_status_i,
    output logic printer_irq_out_o
);
    import ppp_pkg::*;

    // ==================================================
    // Registers
    logic [7:0] data_latch_reg;
    logic [5:0] ctl_reg;
    logic dir_code_in_reg;
    logic input_mode;
    bus_state_e bus_state_reg;

    // ==================================================
    // Synchronisers: 8 data, 4 handshake, 5 status, 2 straps
    localparam int SYNC_W = 19;
    logic [SYNC_W-1:0] sync_q;
    logic [7:0] data_pins_s;
    hs_lines_s hs_s;
    printer_status_s sts_s;
    logic pin_mode_s;
    logic latch_sel_s;

    ppp_sync2 #(.WIDTH(SYNC_W)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i({parallel_data_pins_i, hs_pins_i, printer_status_i,
              direction_pin_mode_i, ack_latch_select_i}),
        .rst_val_i({SYNC_W{1'b1}}),
        .q_o(sync_q)
    );

    assign {data_pins_s, hs_s, sts_s, pin_mode_s, latch_sel_s} = sync_q;

    // ==================================================
    // Bus decode
    logic bus_req;
    logic wr_en;
    logic rd_en;
    logic [7:0] wbyte;

    assign bus_req = cyc_i && stb_i && (bus_state_reg == BUS_IDLE);
    assign wr_en = bus_req && we_i && sel_i[0];
    assign rd_en = bus_req && !we_i;
    assign wbyte = dat_i[7:0];

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a[3:2] == r[3:2]) && (a[1:0] == ADDR_SEL_BITS);
    endfunction

    // Direction code shares the data latch offset via the upper byte lane
    logic dir_wr;
    assign dir_wr = bus_req && we_i && sel_i[1] && hit(adr_i, ADDR_DIR_CODE);

    // ==================================================
    // Acknowledge latch
    logic pending_n;
    logic status_read;

    // Clear fires when the read is accepted in BUS_IDLE, the same edge that captures dat_o and raises ack_o
    assign status_read = rd_en && hit(adr_i, ADDR_PORT_STATUS);

    ppp_ack_latch u_ack (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .ack_n_i(sts_s.ack_n),
        .latch_sel_i(latch_sel_s),
        .status_read_i(status_read),
        .pending_n_o(pending_n)
    );

    // ==================================================
    // Register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_latch_reg <= DATA_RESET;
        end else if (ce_i && wr_en && hit(adr_i, ADDR_DATA_LATCH)) begin
            data_latch_reg <= wbyte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg <= CTL_RESET;
        end else if (ce_i && wr_en && hit(adr_i, ADDR_LINE_DRIVE)) begin
            ctl_reg <= wbyte[5:0];
        end
    end

    // Other codes leave the direction unchanged
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_code_in_reg <= 1'b0;
        end else if (ce_i && dir_wr) begin
            if (dat_i[15:8] == DIR_CODE_OUT) begin
                dir_code_in_reg <= 1'b0;
            end else if (dat_i[15:8] == DIR_CODE_IN) begin
                dir_code_in_reg <= 1'b1;
            end
        end
    end

    always_comb begin
        if (pin_mode_s) begin
            input_mode = ctl_reg[CTL_DIR];
        end else begin
            input_mode = dir_code_in_reg;
        end
    end

    // ==================================================
    // Read mux
    logic [7:0] status_byte;
    logic [7:0] readback_byte;
    logic [31:0] rd_word;

    always_comb begin
        status_byte = STS_UNUSED;
        status_byte[STS_IRQ] = pending_n;
        status_byte[STS_ERROR] = sts_s.error_n;
        status_byte[STS_SELECTED] = sts_s.selected_in;
        status_byte[STS_PAPER] = sts_s.paper_empty_in;
        status_byte[STS_ACK] = sts_s.ack_n;
        status_byte[STS_BUSY] = sts_s.busy;
        readback_byte = RBK_UNUSED;
        readback_byte[CTL_STROBE] = !hs_s.strobe_n;
        readback_byte[CTL_LFEED] = !hs_s.line_feed_ctrl;
        readback_byte[CTL_RESTART] = hs_s.restart;
        readback_byte[CTL_SELREQ] = !hs_s.select_request_out;
        readback_byte[CTL_IRQ_EN] = ctl_reg[CTL_IRQ_EN];
        rd_word = UNMAPPED_READ;
        if (hit(adr_i, ADDR_DATA_LATCH)) begin
            rd_word[7:0] = input_mode ? data_pins_s : data_latch_reg;
        end else if (hit(adr_i, ADDR_PORT_STATUS)) begin
            rd_word[7:0] = status_byte;
        end else if (hit(adr_i, ADDR_LINE_READBACK)) begin
            rd_word[7:0] = readback_byte;
        end else if (hit(adr_i, ADDR_LINE_DRIVE)) begin
            // Write-only: unused bits 7-6 still read as one
            rd_word[7:0] = {2'b11, 6'h00};
        end
    end

    // ==================================================
    // Bus handshake: one wait state, ack stands one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state_reg <= BUS_IDLE;
            ack_o <= 1'b0;
            dat_o <= UNMAPPED_READ;
        end else if (ce_i) begin
            case (bus_state_reg)
                BUS_IDLE: begin
                    if (cyc_i && stb_i) begin
                        bus_state_reg <= BUS_ACK;
                        ack_o <= 1'b1;
                        dat_o <= rd_word;
                    end
                end
                BUS_ACK: begin
                    bus_state_reg <= BUS_IDLE;
                    ack_o <= 1'b0;
                end
                default: begin
                    bus_state_reg <= BUS_IDLE;
                    ack_o <= 1'b0;
                end
            endcase
        end
    end

    // ==================================================
    // Pin drive, all from flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            parallel_data_pins_o <= DATA_RESET;
            parallel_data_pins_oe_o <= 8'hff;
        end else if (ce_i) begin
            parallel_data_pins_o <= data_latch_reg;
            parallel_data_pins_oe_o <= {8{!input_mode}};
        end
    end

    // Open drain: output value is always 0, enable pulls low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hs_pins_o <= '0;
            hs_pins_oe_o <= '{strobe_n: 1'b0, line_feed_ctrl: 1'b0,
                              restart: 1'b1, select_request_out: 1'b0};
        end else if (ce_i) begin
            hs_pins_o <= '0;
            hs_pins_oe_o.strobe_n <= ctl_reg[CTL_STROBE];
            hs_pins_oe_o.line_feed_ctrl <= ctl_reg[CTL_LFEED];
            hs_pins_oe_o.restart <= !ctl_reg[CTL_RESTART];
            hs_pins_oe_o.select_request_out <= ctl_reg[CTL_SELREQ];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            printer_irq_out_o <= 1'b1;
        end else if (ce_i) begin
            printer_irq_out_o <= !(!pending_n && ctl_reg[CTL_IRQ_EN]);
        end
    end
endmodule
`default_nettype wire

/* File: dv/ppp_properties.sv */
// Checker for the parallel host port, bound to its top module.
// Assumes ce_i high and straps settled before the bus writes.
`timescale 1ns/1ps
`default_nettype none
module ppp_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic direction_pin_mode_i,
    input wire logic [7:0] parallel_data_pins_o,
    input wire logic [7:0] parallel_data_pins_oe_o,
    input wire ppp_pkg::hs_lines_s hs_pins_oe_o,
    input wire ppp_pkg::printer_status_s printer_status_i,
    input wire logic printer_irq_out_o
);
    import ppp_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic wr, ld, en_reg;
    assign wr = cyc_i && stb_i && !ack_o && we_i;
    assign ld = wr && adr_i == ADDR_LINE_DRIVE && sel_i[0];
    // =====
    // Mirror of the interrupt enable; pins lag it, so it is cheap to keep
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg <= 1'b0;
        end else if (ld) begin
            en_reg <= dat_i[CTL_IRQ_EN];
        end
    end
    // =====
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus answer late or long");
    status_unused_a: assert property (ack_o && !we_i && adr_i == ADDR_PORT_STATUS
        |-> dat_o[1:0] == 2'h3) else $error("status spare bits");
    line_unused_a: assert property (ack_o && !we_i && adr_i == ADDR_LINE_READBACK
        |-> dat_o[7:5] == 3'h7) else $error("readback spare bits");
    data_drive_a: assert property (wr && adr_i == ADDR_DATA_LATCH && sel_i[0]
        |-> ##2 parallel_data_pins_o == $past(dat_i[7:0], 2))
        else $error("data pins");
    strobe_level_a: assert property (ld |-> ##2
        hs_pins_oe_o[3] == $past(dat_i[CTL_STROBE], 2)) else $error("strobe");
    ctrl_lines_a: assert property (ld |-> ##2 hs_pins_oe_o[2:0] ==
        {$past(dat_i[1], 2), !$past(dat_i[2], 2), $past(dat_i[3], 2)})
        else $error("control lines");
    code_dir_a: assert property (wr && adr_i == ADDR_DIR_CODE && sel_i[1]
        && !direction_pin_mode_i
        && (dat_i[15:8] == DIR_CODE_IN || dat_i[15:8] == DIR_CODE_OUT)
        |-> ##2 parallel_data_pins_oe_o == {8{$past(dat_i[8], 2)}})
        else $error("code direction");
    code_ignored_a: assert property (wr && adr_i == ADDR_DIR_CODE && sel_i[1]
        && direction_pin_mode_i |=> $stable(parallel_data_pins_oe_o) [*2])
        else $error("code not ignored");
    bit_dir_a: assert property (ld && direction_pin_mode_i |-> ##2
        parallel_data_pins_oe_o == {8{!$past(dat_i[CTL_DIR], 2)}})
        else $error("bit direction");
    irq_masked_a: assert property (!en_reg [*3] |-> printer_irq_out_o)
        else $error("irq not masked");
    irq_raise_a: assert property ((en_reg && !printer_status_i.ack_n) [*7]
        |-> !printer_irq_out_o) else $error("irq missing");
    cover property (wr && adr_i == ADDR_DIR_CODE && sel_i[1]);
    cover property (!printer_irq_out_o);
    cover property (ld && direction_pin_mode_i);
endmodule
bind printer_parallel_port ppp_properties ppp_properties_i (.*);
`default_nettype wire

/* File: dv/printer_model.sv */
// Printer-side model: pull-ups on the handshake wires and a data driver.
// Assumes the bench commands when the far side drives or sinks lines.
`timescale 1ns/1ps
`default_nettype none
module printer_model (
    input wire logic clk_i,
    input wire logic [7:0] pd_o_i,
    input wire logic [7:0] pd_oe_i,
    input wire logic [3:0] hs_oe_i,
    input wire logic drive_i,
    input wire logic [7:0] drive_val_i,
    input wire logic [3:0] pull_i,
    output logic [7:0] pd_o,
    output logic [3:0] hs_o
);
    logic [7:0] last_reg;
    // Undriven pins toggle so a stale value never passes for data
    always_ff @(posedge clk_i) begin
        last_reg <= pd_o;
    end
    assign hs_o = ~(hs_oe_i | pull_i);
    assign pd_o = (pd_oe_i & pd_o_i)
        | (~pd_oe_i & (drive_i ? drive_val_i : ~last_reg));
endmodule
`default_nettype wire

/* File: dv/printer_parallel_port_tb.sv */
// Self-checking bench for the parallel host port.
// Assumes the printer model resolves all shared pins.
`timescale 1ns/1ps
`default_nettype none
module printer_parallel_port_tb;
    import ppp_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic we_i = 1'b0, ack_o, printer_irq_out_o, drive = 1'b0;
    logic direction_pin_mode_i = 1'b0, ack_latch_select_i = 1'b0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h0, pull = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [7:0] parallel_data_pins_i, parallel_data_pins_o;
    logic [7:0] parallel_data_pins_oe_o, drive_val = 8'h00;
    hs_lines_s hs_pins_i, hs_pins_oe_o;
    printer_status_s printer_status_i = 5'h19;
    int n_fail = 0, n_checks = 0;
    always #25 clk_i = ~clk_i;
    printer_parallel_port printer_parallel_port_i (.*, .ce_i(1'b1),
        .hs_pins_o());
    printer_model printer_model_i (.clk_i, .pd_o_i(parallel_data_pins_o),
        .pd_oe_i(parallel_data_pins_oe_o), .hs_oe_i(hs_pins_oe_o),
        .drive_i(drive), .drive_val_i(drive_val), .pull_i(pull),
        .pd_o(parallel_data_pins_i), .hs_o(hs_pins_i));
    // =====
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [3:0] s, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            complete_run();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 4'hf, 32'h0);
        check(rd, e);
    endtask
    // Pin paths pass two synchroniser flops, so allow a fixed margin
    task automatic settle();
        repeat (8) @(posedge clk_i);
    endtask
    // =====
    task automatic t_reset();
        // After settle() the synchronisers carry the sampled inputs, no longer their all-ones reset value
        settle();
        rdc(ADDR_PORT_STATUS, 32'hcf);
        rdc(ADDR_LINE_READBACK, 32'he0);
        rdc(ADDR_LINE_DRIVE, 32'hc0);
        rdc(4'h2, 32'h0);
        $display("reset values done");
    endtask
    task automatic t_lines();
        for (int p = 0; p < 32; p++) begin
            bus(1'b1, ADDR_LINE_DRIVE, 4'h1, 32'(p));
            settle();
            check(32'(hs_pins_oe_o), {28'h0, p[0], p[1], ~p[2], p[3]});
            rdc(ADDR_LINE_READBACK, 32'he0 | 32'(p));
            check(32'(printer_irq_out_o), 32'h1);
        end
        bus(1'b1, ADDR_LINE_DRIVE, 4'h1, 32'h0);
        pull <= 4'h8;
        settle();
        rdc(ADDR_LINE_READBACK, 32'he1);
        pull <= 4'h0;
        $display("control lines done");
    endtask
    task automatic t_data();
        bus(1'b1, ADDR_DATA_LATCH, 4'h1, 32'ha5);
        settle();
        check(32'(parallel_data_pins_o), 32'ha5);
        rdc(ADDR_DATA_LATCH, 32'ha5);
        drive <= 1'b1;
        drive_val <= 8'h3c;
        bus(1'b1, ADDR_DIR_CODE, 4'h2, 32'haa00);
        settle();
        check(32'(parallel_data_pins_oe_o), 32'h0);
        rdc(ADDR_DATA_LATCH, 32'h3c);
        bus(1'b1, ADDR_DIR_CODE, 4'h2, 32'h1200);
        bus(1'b1, ADDR_DIR_CODE, 4'h2, 32'h5500);
        settle();
        check(32'(parallel_data_pins_oe_o), 32'hff);
        rdc(ADDR_DATA_LATCH, 32'ha5);
        drive <= 1'b0;
        direction_pin_mode_i <= 1'b1;
        settle();
        bus(1'b1, ADDR_DIR_CODE, 4'h2, 32'haa00);
        settle();
        check(32'(parallel_data_pins_oe_o), 32'hff);
        bus(1'b1, ADDR_LINE_DRIVE, 4'h1, 32'h20);
        settle();
        check(32'(parallel_data_pins_oe_o), 32'h0);
        rdc(ADDR_LINE_READBACK, 32'he0);
        bus(1'b1, ADDR_LINE_DRIVE, 4'h1, 32'h0);
        settle();
        check(32'(parallel_data_pins_oe_o), 32'hff);
        direction_pin_mode_i <= 1'b0;
        $display("direction done");
    endtask
    task automatic t_ack();
        printer_status_s v;
        for (int i = 0; i < 5; i++) begin
            v = 5'h19 ^ (5'h1 << i);
            printer_status_i <= v;
            settle();
            rdc(ADDR_PORT_STATUS, {24'h0, v, v[3], 2'h3});
            check(32'(printer_irq_out_o), 32'h1);
        end
        bus(1'b1, ADDR_LINE_DRIVE, 4'h1, 32'h10);
        printer_status_i <= 5'h11;
        settle();
        check(32'(printer_irq_out_o), 32'h0);
        printer_status_i <= 5'h19;
        settle();
        check(32'(printer_irq_out_o), 32'h1);
        ack_latch_select_i <= 1'b1;
        settle();
        printer_status_i <= 5'h11;
        repeat (3) @(posedge clk_i);
        printer_status_i <= 5'h19;
        settle();
        check(32'(printer_irq_out_o), 32'h0);
        rdc(ADDR_PORT_STATUS, 32'hcb);
        rdc(ADDR_PORT_STATUS, 32'hcf);
        settle();
        check(32'(printer_irq_out_o), 32'h1);
        $display("acknowledge done");
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_lines();
        t_data();
        t_ack();
        complete_run();
    end
endmodule
`default_nettype wire
